/* File: hdl/string_arith_unit.sv */
// Chosen here: the register offsets and the APB slave port.
module string_arith_unit (
	input  wire logic                           core_clk,
	input  wire logic                           nrst,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [exec_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [exec_pkg::PDATA_W-1:0]   pwdata,
	output logic      [exec_pkg::PDATA_W-1:0]   prdata,
	output logic                                pready,
	output logic                                pslverr,
	output logic                                mem_req,
	output logic                                mem_write,
	output logic                                mem_word,
	output logic      [exec_pkg::DATA_W-1:0]    mem_addr,
	output logic      [exec_pkg::DATA_W-1:0]    mem_wdata,
	input  wire logic                           mem_ack,
	input  wire logic [exec_pkg::DATA_W-1:0]    mem_rdata
);

	logic [exec_pkg::PDATA_W-1:0] prdata_q, prdata_d;
	logic                         pready_q, pready_d;
	logic                         pslverr_q, pslverr_d;
	logic                         bus_wr;
	logic                         hit;

	exec_pkg::state_t             state_q, state_d;
	exec_pkg::op_t                op_q, op_d;
	logic                         word_q, word_d;
	logic                         iter_q, iter_d;
	logic [exec_pkg::DATA_W-1:0]  flags_q, flags_d;
	logic [exec_pkg::DATA_W-1:0]  acc_q, acc_d;
	logic [exec_pkg::DATA_W-1:0]  ext_q, ext_d;
	logic [exec_pkg::DATA_W-1:0]  opnd_q, opnd_d;
	logic [exec_pkg::DATA_W-1:0]  src_q, src_d;
	logic [exec_pkg::DATA_W-1:0]  dst_q, dst_d;
	logic [exec_pkg::DATA_W-1:0]  cnt_q, cnt_d;
	logic                         mem_req_q, mem_req_d;
	logic                         mem_write_q, mem_write_d;
	logic [exec_pkg::DATA_W-1:0]  mem_addr_q, mem_addr_d;
	logic [exec_pkg::DATA_W-1:0]  mem_wdata_q, mem_wdata_d;

	logic [2*exec_pkg::BYTE_W-1:0] prod_b;
	logic [2*exec_pkg::DATA_W-1:0] prod_w;
	logic [exec_pkg::BYTE_W-1:0]   inv_b, neg_b;
	logic [exec_pkg::DATA_W-1:0]   inv_w, neg_w;
	logic [exec_pkg::DATA_W-1:0]   step;
	logic [exec_pkg::DATA_W-1:0]   cnt_dec;
	logic                          busy;

	assign busy   = (state_q != exec_pkg::ST_IDLE);
	// Write takes effect at the edge where the master sees pready high
	assign bus_wr = psel & penable & pwrite & pready_q;

	// Zero-extended operands: the product is purely unsigned
	assign prod_b  = {{exec_pkg::BYTE_W{1'b0}}, acc_q[exec_pkg::BYTE_W-1:0]}
		* {{exec_pkg::BYTE_W{1'b0}}, opnd_q[exec_pkg::BYTE_W-1:0]};
	assign prod_w  = {{exec_pkg::DATA_W{1'b0}}, acc_q} * {{exec_pkg::DATA_W{1'b0}}, opnd_q};
	assign inv_b   = exec_pkg::ONES_BYTE - opnd_q[exec_pkg::BYTE_W-1:0];
	assign inv_w   = exec_pkg::ONES_WORD - opnd_q;
	assign neg_b   = inv_b + exec_pkg::ONE_BYTE;
	assign neg_w   = inv_w + exec_pkg::ONE_WORD;
	assign step    = word_q ? exec_pkg::DELTA_WORD : exec_pkg::DELTA_BYTE;
	assign cnt_dec = cnt_q - exec_pkg::ONE_WORD;

	// APB slave: one wait state, pready pulses for one cycle
	always_comb begin
		pready_d  = psel & penable & ~pready_q;
		pslverr_d = 1'b0;
		prdata_d  = prdata_q;
		hit       = 1'b1;
		if (pready_d) begin
			prdata_d = '0;
			unique case (paddr)
				exec_pkg::OFS_CTRL: begin
					prdata_d[exec_pkg::CTRL_OP_LSB +: exec_pkg::CTRL_OP_W] = op_q;
					prdata_d[exec_pkg::CTRL_WORD] = word_q;
					prdata_d[exec_pkg::CTRL_ITER] = iter_q;
				end
				exec_pkg::OFS_STATUS:  prdata_d[exec_pkg::STAT_BUSY] = busy;
				exec_pkg::OFS_FLAGS:   prdata_d[exec_pkg::DATA_W-1:0] = flags_q;
				exec_pkg::OFS_ACC:     prdata_d[exec_pkg::DATA_W-1:0] = acc_q;
				exec_pkg::OFS_EXT:     prdata_d[exec_pkg::DATA_W-1:0] = ext_q;
				exec_pkg::OFS_OPERAND: prdata_d[exec_pkg::DATA_W-1:0] = opnd_q;
				exec_pkg::OFS_SRC_IDX: prdata_d[exec_pkg::DATA_W-1:0] = src_q;
				exec_pkg::OFS_DST_IDX: prdata_d[exec_pkg::DATA_W-1:0] = dst_q;
				exec_pkg::OFS_COUNT:   prdata_d[exec_pkg::DATA_W-1:0] = cnt_q;
				default:               hit = 1'b0;
			endcase
			pslverr_d = ~hit;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Execution core
	always_comb begin
		state_d     = state_q;
		op_d        = op_q;
		word_d      = word_q;
		iter_d      = iter_q;
		flags_d     = flags_q;
		acc_d       = acc_q;
		ext_d       = ext_q;
		opnd_d      = opnd_q;
		src_d       = src_q;
		dst_d       = dst_q;
		cnt_d       = cnt_q;
		mem_req_d   = mem_req_q & ~mem_ack;
		mem_write_d = mem_write_q;
		mem_addr_d  = mem_addr_q;
		mem_wdata_d = mem_wdata_q;
		// Software writes are ignored while an operation runs
		if (bus_wr && !busy) begin
			unique case (paddr)
				exec_pkg::OFS_CTRL: begin
					op_d   = exec_pkg::op_t'(pwdata[exec_pkg::CTRL_OP_LSB +: exec_pkg::CTRL_OP_W]);
					word_d = pwdata[exec_pkg::CTRL_WORD];
					iter_d = pwdata[exec_pkg::CTRL_ITER];
					if (pwdata[exec_pkg::CTRL_START])
						state_d = exec_pkg::ST_EXEC;
				end
				exec_pkg::OFS_FLAGS:   flags_d = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::OFS_ACC:     acc_d   = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::OFS_EXT:     ext_d   = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::OFS_OPERAND: opnd_d  = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::OFS_SRC_IDX: src_d   = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::OFS_DST_IDX: dst_d   = pwdata[exec_pkg::DATA_W-1:0];
				exec_pkg::OFS_COUNT:   cnt_d   = pwdata[exec_pkg::DATA_W-1:0];
				default: ;
			endcase
		end
		unique case (state_q)
			exec_pkg::ST_IDLE: ;
			exec_pkg::ST_EXEC: begin
				state_d = exec_pkg::ST_IDLE;
				unique case (op_q)
					exec_pkg::string_copy_op: begin
						if (!(iter_q && cnt_q == exec_pkg::RST_WORD)) begin
							state_d     = exec_pkg::ST_READ;
							mem_req_d   = 1'b1;
							mem_write_d = 1'b0;
							mem_addr_d  = src_q;
						end
					end
					exec_pkg::unsigned_product_op: begin
						// Undefined flags and control flags are simply kept
						if (word_q) begin
							{ext_d, acc_d} = prod_w;
							flags_d[exec_pkg::FL_CARRY] = |prod_w[2*exec_pkg::DATA_W-1:exec_pkg::DATA_W];
						end else begin
							acc_d = prod_b;
							flags_d[exec_pkg::FL_CARRY] = |prod_b[2*exec_pkg::BYTE_W-1:exec_pkg::BYTE_W];
						end
						flags_d[exec_pkg::FL_OVF] = flags_d[exec_pkg::FL_CARRY];
					end
					exec_pkg::twos_complement_op: begin
						flags_d[exec_pkg::FL_AUX]   = |opnd_q[exec_pkg::BYTE_W/2-1:0];
						if (word_q) begin
							opnd_d = neg_w;
							flags_d[exec_pkg::FL_CARRY] = (opnd_q != exec_pkg::RST_WORD);
							flags_d[exec_pkg::FL_OVF]   = (opnd_q == exec_pkg::MIN_WORD);
							flags_d[exec_pkg::FL_ZERO]  = (neg_w == exec_pkg::RST_WORD);
							flags_d[exec_pkg::FL_SIGN]  = neg_w[exec_pkg::DATA_W-1];
						end else begin
							opnd_d[exec_pkg::BYTE_W-1:0] = neg_b;
							flags_d[exec_pkg::FL_CARRY] = |opnd_q[exec_pkg::BYTE_W-1:0];
							flags_d[exec_pkg::FL_OVF]   = (opnd_q[exec_pkg::BYTE_W-1:0] == exec_pkg::MIN_BYTE);
							flags_d[exec_pkg::FL_ZERO]  = ~|neg_b;
							flags_d[exec_pkg::FL_SIGN]  = neg_b[exec_pkg::BYTE_W-1];
						end
						flags_d[exec_pkg::FL_PAR] = ~^neg_b;
					end
					exec_pkg::invert_op: begin
						if (word_q)
							opnd_d = inv_w;
						else
							opnd_d[exec_pkg::BYTE_W-1:0] = inv_b;
					end
					default: ;
				endcase
			end
			exec_pkg::ST_READ: begin
				if (mem_req_q && mem_ack) begin
					state_d     = exec_pkg::ST_WRITE;
					mem_req_d   = 1'b1;
					mem_write_d = 1'b1;
					mem_addr_d  = dst_q;
					mem_wdata_d = mem_rdata;
				end
			end
			exec_pkg::ST_WRITE: begin
				if (mem_req_q && mem_ack) begin
					mem_write_d = 1'b0;
					state_d     = exec_pkg::ST_IDLE;
					if (flags_q[exec_pkg::FL_DIR]) begin
						src_d = src_q - step;
						dst_d = dst_q - step;
					end else begin
						src_d = src_q + step;
						dst_d = dst_q + step;
					end
					if (iter_q) begin
						cnt_d = cnt_dec;
						if (cnt_dec != exec_pkg::RST_WORD) begin
							state_d    = exec_pkg::ST_READ;
							mem_req_d  = 1'b1;
							mem_addr_d = src_d;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_q     <= exec_pkg::ST_IDLE;
			op_q        <= exec_pkg::idle_op;
			word_q      <= 1'b0;
			iter_q      <= 1'b0;
			flags_q     <= exec_pkg::RST_WORD;
			acc_q       <= exec_pkg::RST_WORD;
			ext_q       <= exec_pkg::RST_WORD;
			opnd_q      <= exec_pkg::RST_WORD;
			src_q       <= exec_pkg::RST_WORD;
			dst_q       <= exec_pkg::RST_WORD;
			cnt_q       <= exec_pkg::RST_WORD;
			mem_req_q   <= 1'b0;
			mem_write_q <= 1'b0;
			mem_addr_q  <= exec_pkg::RST_WORD;
			mem_wdata_q <= exec_pkg::RST_WORD;
		end else begin
			state_q     <= state_d;
			op_q        <= op_d;
			word_q      <= word_d;
			iter_q      <= iter_d;
			flags_q     <= flags_d;
			acc_q       <= acc_d;
			ext_q       <= ext_d;
			opnd_q      <= opnd_d;
			src_q       <= src_d;
			dst_q       <= dst_d;
			cnt_q       <= cnt_d;
			mem_req_q   <= mem_req_d;
			mem_write_q <= mem_write_d;
			mem_addr_q  <= mem_addr_d;
			mem_wdata_q <= mem_wdata_d;
		end
	end

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign mem_req   = mem_req_q;
	assign mem_write = mem_write_q;
	assign mem_word  = word_q;
	assign mem_addr  = mem_addr_q;
	assign mem_wdata = mem_wdata_q;

	logic ex_mul, ex_neg, ex_inv, ex_idle, wr_done, rd_done;
	assign ex_mul  = (state_q == exec_pkg::ST_EXEC) && (op_q == exec_pkg::unsigned_product_op);
	assign ex_neg  = (state_q == exec_pkg::ST_EXEC) && (op_q == exec_pkg::twos_complement_op);
	assign ex_inv  = (state_q == exec_pkg::ST_EXEC) && (op_q == exec_pkg::invert_op);
	assign ex_idle = (state_q == exec_pkg::ST_EXEC) && (op_q == exec_pkg::idle_op);
	assign rd_done = (state_q == exec_pkg::ST_READ) && mem_req_q && mem_ack;
	assign wr_done = (state_q == exec_pkg::ST_WRITE) && mem_req_q && mem_ack;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_copy_data_path: assert property (rd_done |=> mem_write_q && mem_req_q && mem_addr_q == $past(dst_q)
		&& mem_wdata_q == $past(mem_rdata)) else $error("copied element or target address wrong");
	a_repeat_continue: assert property (wr_done && iter_q && cnt_q > exec_pkg::ONE_WORD
		|=> state_q == exec_pkg::ST_READ && mem_addr_q == src_q) else $error("block transfer did not continue");
	a_index_step: assert property (wr_done |=> src_q == ($past(flags_q[exec_pkg::FL_DIR])
		? $past(src_q) - $past(step) : $past(src_q) + $past(step))) else $error("index step wrong");
	a_mul_byte_result: assert property (ex_mul && !word_q |=> acc_q == $past(prod_b) && $stable(ext_q)
		&& flags_q[exec_pkg::FL_CARRY] == ($past(prod_b) > 16'h00ff)) else $error("byte product or carry wrong");
	a_mul_word_split: assert property (ex_mul && word_q
		|=> {ext_q, acc_q} == {16'h0000, $past(acc_q)} * {16'h0000, $past(opnd_q)})
		else $error("word product split wrong");
	a_mul_ovf_carry: assert property (ex_mul |=> flags_q[exec_pkg::FL_OVF] == flags_q[exec_pkg::FL_CARRY]
		&& flags_q[exec_pkg::FL_DIR] == $past(flags_q[exec_pkg::FL_DIR])) else $error("overflow differs from carry");
	a_neg_word_value: assert property (ex_neg && word_q |=> opnd_q + $past(opnd_q) == exec_pkg::RST_WORD)
		else $error("negated word wrong");
	a_neg_min_kept: assert property (ex_neg && word_q && opnd_q == exec_pkg::MIN_WORD
		|=> opnd_q == exec_pkg::MIN_WORD && flags_q[exec_pkg::FL_OVF]) else $error("minimum negate wrong");
	a_neg_zero_kept: assert property (ex_neg && opnd_q == exec_pkg::RST_WORD
		|=> opnd_q == exec_pkg::RST_WORD && !flags_q[exec_pkg::FL_CARRY] && flags_q[exec_pkg::FL_ZERO])
		else $error("zero negate wrong");
	a_idle_no_change: assert property (ex_idle |=> $stable(flags_q) && $stable(acc_q) && $stable(opnd_q)
		&& state_q == exec_pkg::ST_IDLE) else $error("idle op changed state");
	a_invert_flags: assert property (ex_inv && word_q |=> opnd_q == ~$past(opnd_q) && $stable(flags_q))
		else $error("invert result or flags wrong");
	a_copy_flags_kept: assert property ((state_q == exec_pkg::ST_READ || state_q == exec_pkg::ST_WRITE)
		|=> $stable(flags_q)) else $error("copy altered flags");
	a_count_down: assert property (wr_done && iter_q |=> cnt_q == $past(cnt_q) - exec_pkg::ONE_WORD
		##0 (cnt_q == exec_pkg::RST_WORD) == (state_q == exec_pkg::ST_IDLE)) else $error("count step wrong");
	a_ready_pulse: assert property (pready_q |=> !pready_q) else $error("pready held longer than one cycle");

	c_mul_carry: cover property (ex_mul && word_q ##1 flags_q[exec_pkg::FL_CARRY]);
	c_neg_min: cover property (ex_neg && opnd_q == exec_pkg::MIN_WORD);
	c_block_copy: cover property (wr_done && iter_q ##1 state_q == exec_pkg::ST_READ);
	c_bad_addr: cover property (pready_q && pslverr_q);

endmodule : string_arith_unit

/* File: hdl/exec_pkg.sv */
package exec_pkg;

	localparam int unsigned DATA_W  = 16;
	localparam int unsigned BYTE_W  = 8;
	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned PDATA_W = 32;

	// Register byte offsets on the APB
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_ACC     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_EXT     = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_OPERAND = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_SRC_IDX = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_DST_IDX = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h20;

	// Control and status register fields
	localparam int unsigned CTRL_OP_LSB = 0;
	localparam int unsigned CTRL_OP_W   = 3;
	localparam int unsigned CTRL_WORD   = 3;
	localparam int unsigned CTRL_ITER   = 4;
	localparam int unsigned CTRL_START  = 8;
	localparam int unsigned STAT_BUSY   = 0;

	// Flag word positions
	localparam int unsigned FL_CARRY = 0;
	localparam int unsigned FL_PAR   = 2;
	localparam int unsigned FL_AUX   = 4;
	localparam int unsigned FL_ZERO  = 6;
	localparam int unsigned FL_SIGN  = 7;
	localparam int unsigned FL_TRAP  = 8;
	localparam int unsigned FL_INTR  = 9;
	localparam int unsigned FL_DIR   = 10;
	localparam int unsigned FL_OVF   = 11;

	localparam logic [DATA_W-1:0] RST_WORD   = 16'h0000;
	localparam logic [BYTE_W-1:0] ONES_BYTE  = 8'hff;
	localparam logic [DATA_W-1:0] ONES_WORD  = 16'hffff;
	localparam logic [BYTE_W-1:0] ONE_BYTE   = 8'h01;
	localparam logic [DATA_W-1:0] ONE_WORD   = 16'h0001;
	localparam logic [BYTE_W-1:0] MIN_BYTE   = 8'h80;
	localparam logic [DATA_W-1:0] MIN_WORD   = 16'h8000;
	localparam logic [DATA_W-1:0] DELTA_BYTE = 16'h0001;
	localparam logic [DATA_W-1:0] DELTA_WORD = 16'h0002;

	typedef enum logic [2:0] {
		idle_op             = 3'h0,
		string_copy_op      = 3'h1,
		unsigned_product_op = 3'h2,
		twos_complement_op  = 3'h3,
		invert_op           = 3'h4
	} op_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_EXEC  = 4'b0010,
		ST_READ  = 4'b0100,
		ST_WRITE = 4'b1000
	} state_t;

endpackage : exec_pkg

/* File: verif/mem_model.sv */
module mem_model (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        mem_req,
	input  wire logic        mem_write,
	input  wire logic        mem_word,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	input  wire logic [3:0]  wait_cycles,
	output logic             mem_ack,
	output logic      [15:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0]  mem [256];
	logic [3:0]  cnt_q;
	logic [15:0] rd_q;
	logic [7:0]  a;

	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);

	assign a = mem_addr[7:0];
	// Outside the answer cycle the data lines show the inverse of the last value
	assign mem_rdata = mem_ack ? rd_q : ~rd_q;

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'b0;
			cnt_q <= 4'h0;
			rd_q <= 16'h0000;
		end else if (mem_ack) begin
			mem_ack <= 1'b0;
			cnt_q <= 4'h0;
			if (mem_req && mem_write) begin
				mem[a] <= mem_wdata[7:0];
				if (mem_word) mem[a + 8'h01] <= mem_wdata[15:8];
			end
		end else if (mem_req) begin
			if (cnt_q >= wait_cycles) begin
				mem_ack <= 1'b1;
				// Byte reads carry junk in the upper half
				rd_q <= {mem_word ? mem[a + 8'h01] : ~mem[a], mem[a]};
			end else begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
endmodule : mem_model

/* File: verif/mul_negate_invert_string_copy_tb.sv */
module mul_negate_invert_string_copy_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic        mem_req, mem_write, mem_word, mem_ack;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	logic [3:0]  wait_cycles;
	logic        e;
	int          n_fail, compares;

	string_arith_unit uut (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .mem_req, .mem_write, .mem_word, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
	mem_model mem_u (.core_clk, .nrst, .mem_req, .mem_write, .mem_word, .mem_addr, .mem_wdata,
		.wait_cycles, .mem_ack, .mem_rdata);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	function automatic logic [7:0] f(input logic [7:0] a);
		return 8'(a * 8'd7 + 8'd3);
	endfunction : f

	task automatic stop_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic er);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) n_fail++;
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0000, d}, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] x);
		apb(1'b0, a, 32'h0, r, e);
		chk(r, {16'h0000, x});
	endtask : rd

	task automatic run(input logic [2:0] op, input logic w, input logic it);
		int n;
		wr(exec_pkg::OFS_CTRL, {7'h00, 1'b1, 3'h0, it, w, op});
		n = 0;
		do begin
			apb(1'b0, exec_pkg::OFS_STATUS, 32'h0, r, e);
			n++;
		end while (r[0] !== 1'b0 && n < 200);
		if (n >= 200) n_fail++;
	endtask : run

	task automatic alu(input logic [2:0] op, input logic w, input logic [15:0] acc, opd, fl, eacc, eext,
		eopd, efl);
		wr(exec_pkg::OFS_ACC, acc);
		wr(exec_pkg::OFS_EXT, 16'h5a5a);
		wr(exec_pkg::OFS_OPERAND, opd);
		wr(exec_pkg::OFS_FLAGS, fl);
		run(op, w, 1'b0);
		rd(exec_pkg::OFS_ACC, eacc);
		rd(exec_pkg::OFS_EXT, eext);
		rd(exec_pkg::OFS_OPERAND, eopd);
		rd(exec_pkg::OFS_FLAGS, efl);
	endtask : alu

	task automatic copy(input logic w, it, input logic [15:0] src, dst, cnt, fl, esrc, edst, ecnt);
		wr(exec_pkg::OFS_SRC_IDX, src);
		wr(exec_pkg::OFS_DST_IDX, dst);
		wr(exec_pkg::OFS_COUNT, cnt);
		wr(exec_pkg::OFS_FLAGS, fl);
		run(3'h1, w, it);
		rd(exec_pkg::OFS_SRC_IDX, esrc);
		rd(exec_pkg::OFS_DST_IDX, edst);
		rd(exec_pkg::OFS_COUNT, ecnt);
		rd(exec_pkg::OFS_FLAGS, fl);
	endtask : copy

	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		wait_cycles = 4'h0;
		repeat (12) @(posedge core_clk);
		nrst <= 1'b1;
		rd(exec_pkg::OFS_FLAGS, 16'h0000);
		apb(1'b0, 8'h24, 32'hffffffff, r, e);
		chk(r, 32'h0);
		chk({31'h0, e}, 32'h1);
		alu(3'h2, 1'b0, 16'h12f0, 16'h0020, 16'h07d4, 16'h1e00, 16'h5a5a, 16'h0020, 16'h0fd5);
		alu(3'h2, 1'b0, 16'hff03, 16'h0005, 16'h0801, 16'h000f, 16'h5a5a, 16'h0005, 16'h0000);
		alu(3'h2, 1'b1, 16'hffff, 16'hffff, 16'h0000, 16'h0001, 16'hfffe, 16'hffff, 16'h0801);
		alu(3'h2, 1'b1, 16'h0100, 16'h0020, 16'h0fd5, 16'h2000, 16'h0000, 16'h0020, 16'h07d4);
		alu(3'h3, 1'b1, 16'h1111, 16'h0001, 16'h0700, 16'h1111, 16'h5a5a, 16'hffff, 16'h0795);
		alu(3'h3, 1'b0, 16'h1111, 16'h1200, 16'h0fd5, 16'h1111, 16'h5a5a, 16'h1200, 16'h0744);
		alu(3'h3, 1'b0, 16'h1111, 16'h0080, 16'h0000, 16'h1111, 16'h5a5a, 16'h0080, 16'h0881);
		alu(3'h3, 1'b1, 16'h1111, 16'h8000, 16'h0000, 16'h1111, 16'h5a5a, 16'h8000, 16'h0885);
		alu(3'h4, 1'b1, 16'h1111, 16'h1234, 16'h0fd5, 16'h1111, 16'h5a5a, 16'hedcb, 16'h0fd5);
		alu(3'h4, 1'b0, 16'h1111, 16'ha55a, 16'h0000, 16'h1111, 16'h5a5a, 16'ha5a5, 16'h0000);
		alu(3'h0, 1'b1, 16'h1234, 16'h5678, 16'h0fd5, 16'h1234, 16'h5a5a, 16'h5678, 16'h0fd5);
		alu(3'h5, 1'b0, 16'h1234, 16'h5678, 16'h0000, 16'h1234, 16'h5a5a, 16'h5678, 16'h0000);
		copy(1'b0, 1'b0, 16'h0010, 16'h0040, 16'h0003, 16'h0000, 16'h0011, 16'h0041, 16'h0003);
		chk(mem_u.mem[8'h40], f(8'h10));
		chk(mem_u.mem[8'h41], f(8'h41));
		wait_cycles <= 4'h3;
		copy(1'b1, 1'b1, 16'h0030, 16'h0060, 16'h0003, 16'h0400, 16'h002a, 16'h005a, 16'h0000);
		for (int k = 0; k < 6; k++) chk(mem_u.mem[8'h5c + k], f(8'h2c + k));
		chk(mem_u.mem[8'h5b], f(8'h5b));
		chk(mem_u.mem[8'h62], f(8'h62));
		copy(1'b0, 1'b1, 16'h0080, 16'h0090, 16'h0000, 16'h0fd5, 16'h0080, 16'h0090, 16'h0000);
		chk(mem_u.mem[8'h90], f(8'h90));
		stop_test();
	end
endmodule : mul_negate_invert_string_copy_tb
